// *** verilog/sac_pkg.sv ***
package sac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus and register map
    localparam int          ADDR_W      = 16;
    localparam int          DATA_W      = 32;
    localparam logic [15:0] MODE_OFS    = 16'hFF80;
    localparam logic [15:0] INSEL_OFS   = 16'hFF84;
    localparam logic [15:0] RESULT_OFS  = 16'hFF88;
    localparam logic [15:0] EDGE_OFS    = 16'hFF8C;
    localparam logic [15:0] OSC_OFS     = 16'hFF90;
    localparam logic [15:0] STATUS_OFS  = 16'hFF94;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam int         MODE_CS_BIT  = 7;
    localparam int         MODE_TRG_BIT = 6;
    localparam int         MODE_FR1_BIT = 5;
    localparam int         MODE_FR0_BIT = 4;
    localparam int         MODE_CH_LSB  = 1;
    localparam int         MODE_HSC_BIT = 0;
    localparam int         CH_W         = 3;
    localparam int         STAT_EOC_BIT = 0;
    localparam int         STAT_BSY_BIT = 1;
    localparam logic [7:0] MODE_RST     = 8'h01;
    localparam logic [3:0] INSEL_RST    = 4'h0;
    localparam logic [1:0] EDGE_RST     = 2'h0;
    localparam logic       OSC_RST      = 1'b0;
    localparam logic [1:0] EDGE_FALL    = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Timing: one conversion is CONV_STEPS equal steps
    localparam int         CONV_STEPS = 10;
    localparam int         STEP_W     = 5;
    localparam logic [4:0] STEP_80    = 5'(80 / CONV_STEPS);
    localparam logic [4:0] STEP_40    = 5'(40 / CONV_STEPS);
    localparam logic [4:0] STEP_50    = 5'(50 / CONV_STEPS);
    localparam logic [4:0] STEP_100   = 5'(100 / CONV_STEPS);

    typedef enum logic [1:0] {
        SAR_IDLE    = 2'b00,
        SAR_SAMPLE  = 2'b01,
        SAR_COMPARE = 2'b10,
        SAR_FINISH  = 2'b11
    } sac_sar_state_t;

    typedef enum logic [1:0] {
        CTL_STOP   = 2'b00,
        CTL_ARMED  = 2'b01,
        CTL_SINGLE = 2'b10,
        CTL_REPEAT = 2'b11
    } sac_ctl_state_t;

    typedef enum logic [2:0] {
        SEL_MODE   = 3'h0,
        SEL_INSEL  = 3'h1,
        SEL_RESULT = 3'h2,
        SEL_EDGE   = 3'h3,
        SEL_OSC    = 3'h4,
        SEL_STATUS = 3'h5,
        SEL_NONE   = 3'h7
    } sac_sel_t;

endpackage : sac_pkg

// *** verilog/sac_sar_if.sv ***
interface sac_sar_if;
    logic       start;
    logic       abort;
    logic [4:0] step_ticks;
    logic       comp;
    logic       busy;
    logic       done;
    logic [7:0] result;
    logic [7:0] trial;
    logic       sample;

    modport ctrl (output start, abort, step_ticks, comp,
                  input  busy, done, result, trial, sample);
    modport core (input  start, abort, step_ticks, comp,
                  output busy, done, result, trial, sample);
endinterface : sac_sar_if

// *** verilog/sac_sar_core.sv ***
module sac_sar_core (
    // Clock and reset
    input wire logic    aclk,
    input wire logic    aresetn,
    // Control side
    sac_sar_if.core     sar
);

    sac_pkg::sac_sar_state_t state_reg, state_next;
    logic [4:0] tick_reg;
    logic [2:0] bit_reg;
    logic [7:0] sar_reg;
    logic [7:0] result_reg;
    logic       done_reg;
    logic       step_end;

    assign step_end   = (tick_reg == 5'(sar.step_ticks - 5'h01));
    assign sar.busy   = (state_reg != sac_pkg::SAR_IDLE);
    assign sar.done   = done_reg;
    assign sar.result = result_reg;
    assign sar.trial  = sar_reg;
    assign sar.sample = (state_reg == sac_pkg::SAR_SAMPLE);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            sac_pkg::SAR_IDLE:    if (sar.start) state_next = sac_pkg::SAR_SAMPLE;
            sac_pkg::SAR_SAMPLE:  if (step_end) state_next = sac_pkg::SAR_COMPARE;
            sac_pkg::SAR_COMPARE: if (step_end && bit_reg == 3'h0)
                                      state_next = sac_pkg::SAR_FINISH;
            sac_pkg::SAR_FINISH:  if (step_end) state_next = sac_pkg::SAR_IDLE;
            default:              state_next = sac_pkg::SAR_IDLE;
        endcase
        if (sar.abort)
            state_next = sac_pkg::SAR_IDLE;
    end

    // Held sample: the front end holds while sample is low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= sac_pkg::SAR_IDLE;
            tick_reg  <= 5'h00;
            bit_reg   <= 3'h7;
            sar_reg   <= 8'h00;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            done_reg  <= 1'b0;
            tick_reg  <= (step_end || state_next != state_reg) ? 5'h00 : 5'(tick_reg + 5'h01);
            if (sar.abort || state_reg == sac_pkg::SAR_IDLE)
                tick_reg <= 5'h00;
            if (!sar.abort && state_reg == sac_pkg::SAR_SAMPLE && step_end)
            begin
                sar_reg <= 8'h80;
                bit_reg <= 3'h7;
            end
            if (!sar.abort && state_reg == sac_pkg::SAR_COMPARE && step_end)
            begin
                sar_reg[bit_reg] <= sar.comp;
                if (bit_reg != 3'h0)
                begin
                    sar_reg[3'(bit_reg - 3'h1)] <= 1'b1;
                    bit_reg <= 3'(bit_reg - 3'h1);
                end
            end
            if (!sar.abort && state_reg == sac_pkg::SAR_FINISH && step_end)
                done_reg <= 1'b1;
        end
    end

    // Result keeps no reset value, it is undefined until a conversion ends
    always_ff @(posedge aclk)
    begin
        if (!sar.abort && state_reg == sac_pkg::SAR_FINISH && step_end)
            result_reg <= sar_reg;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_msb_first_trial: assert property (
        (state_reg == sac_pkg::SAR_SAMPLE && step_end && !sar.abort)
        |=> (sar_reg == 8'h80 && bit_reg == 3'h7))
        else $error("first trial code is not the msb");
    a_result_load_done: assert property (
        done_reg |-> (result_reg == $past(sar_reg)))
        else $error("result does not match the approximation");
    a_trial_held_step: assert property (
        (state_reg == sac_pkg::SAR_COMPARE && !step_end && !sar.abort)
        |=> $stable(sar_reg))
        else $error("trial code changed inside a step");
    a_hold_during_conv: assert property (
        (state_reg == sac_pkg::SAR_COMPARE) |-> !sar.sample)
        else $error("sample asserted while comparing");

endmodule : sac_sar_core

// *** verilog/sac_top.sv ***
module sac_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog front end
    input  wire logic        comparator_in,
    output logic [7:0]       trial_code,
    output logic [2:0]       channel_select,
    output logic             sample_enable,
    output logic [7:0]       analog_inputs,
    // Trigger and event
    input  wire logic        external_trigger_input,
    output logic             end_of_conversion_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic sac_pkg::sac_sel_t reg_sel(input logic [15:0] addr);
        logic [15:0] w;
        w = {addr[15:2], 2'b00};
        if (w == sac_pkg::MODE_OFS)        reg_sel = sac_pkg::SEL_MODE;
        else if (w == sac_pkg::INSEL_OFS)  reg_sel = sac_pkg::SEL_INSEL;
        else if (w == sac_pkg::RESULT_OFS) reg_sel = sac_pkg::SEL_RESULT;
        else if (w == sac_pkg::EDGE_OFS)   reg_sel = sac_pkg::SEL_EDGE;
        else if (w == sac_pkg::OSC_OFS)    reg_sel = sac_pkg::SEL_OSC;
        else if (w == sac_pkg::STATUS_OFS) reg_sel = sac_pkg::SEL_STATUS;
        else                               reg_sel = sac_pkg::SEL_NONE;
    endfunction : reg_sel

    // Base clocks per step; zero marks a prohibited code
    function automatic logic [4:0] step_base(input logic [2:0] code);
        case (code)
            3'b001:  step_base = sac_pkg::STEP_80;
            3'b011:  step_base = sac_pkg::STEP_40;
            3'b100:  step_base = sac_pkg::STEP_50;
            3'b101:  step_base = sac_pkg::STEP_100;
            default: step_base = 5'h00;
        endcase
    endfunction : step_base

    // Codes above eight are prohibited and treated as all eight
    function automatic logic [7:0] pin_mask(input logic [3:0] n);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
            if (4'(i) < n)
                m[i] = 1'b1;
        pin_mask = m;
    endfunction : pin_mask

    ////////////////////////////////////////////////////////////////////////
    // Registers and wires

    sac_sar_if sar ();

    logic [7:0]  mode_reg;
    logic [3:0]  insel_reg;
    logic [1:0]  edge_reg;
    logic        osc_reg;
    logic        eoc_flag_reg;
    logic        irq_reg;
    sac_pkg::sac_ctl_state_t ctl_reg, ctl_next;

    logic [15:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        aw_full_reg;
    logic        w_full_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    logic [1:0]  sync_a_reg, sync_b_reg, sync_c_reg;
    logic [1:0]  pin_f_reg;
    logic        trig_prev_reg;

    sac_pkg::sac_sel_t wsel, rsel;
    logic        do_write;
    logic        lane0;
    logic        mode_wr;
    logic        stat_wr;
    logic [4:0]  base;
    logic        rate_ok;
    logic        trig_f;
    logic        trig_edge;
    logic        cs_bit;
    logic        trg_bit;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign wsel     = reg_sel(aw_addr_reg);
    assign rsel     = reg_sel(s_axi_araddr);
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign lane0    = w_strb_reg[0];
    assign mode_wr  = do_write && lane0 && wsel == sac_pkg::SEL_MODE;
    assign stat_wr  = do_write && lane0 && wsel == sac_pkg::SEL_STATUS;

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    assign rd_word =
        (rsel == sac_pkg::SEL_MODE)   ? {24'h000000, mode_reg} :
        (rsel == sac_pkg::SEL_INSEL)  ? {28'h0000000, insel_reg} :
        (rsel == sac_pkg::SEL_RESULT) ? {24'h000000, sar.result} :
        (rsel == sac_pkg::SEL_EDGE)   ? {30'h00000000, edge_reg} :
        (rsel == sac_pkg::SEL_OSC)    ? {31'h00000000, osc_reg} :
        (rsel == sac_pkg::SEL_STATUS) ? {30'h00000000, sar.busy, eoc_flag_reg} :
                                        32'h00000000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= 16'h0000;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= sac_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end
            if (do_write)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (wsel == sac_pkg::SEL_NONE) ? sac_pkg::RESP_SLVERR
                                                           : sac_pkg::RESP_OKAY;
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= sac_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= (rsel == sac_pkg::SEL_NONE) ? sac_pkg::RESP_SLVERR
                                                      : sac_pkg::RESP_OKAY;
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_reg  <= sac_pkg::MODE_RST;
            insel_reg <= sac_pkg::INSEL_RST;
            edge_reg  <= sac_pkg::EDGE_RST;
            osc_reg   <= sac_pkg::OSC_RST;
        end
        else if (do_write && lane0)
        begin
            if (wsel == sac_pkg::SEL_MODE)
                mode_reg <= w_data_reg[7:0];
            if (wsel == sac_pkg::SEL_INSEL)
                insel_reg <= w_data_reg[3:0];
            if (wsel == sac_pkg::SEL_EDGE)
                edge_reg <= w_data_reg[1:0];
            if (wsel == sac_pkg::SEL_OSC)
                osc_reg <= w_data_reg[0];
        end
    end

    // Flag set wins over a same-cycle write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            eoc_flag_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end
        else
        begin
            irq_reg <= sar.done;
            if (sar.done)
                eoc_flag_reg <= 1'b1;
            else if (stat_wr && w_data_reg[sac_pkg::STAT_EOC_BIT])
                eoc_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs: three stages, a change counts once stages two and three agree

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_a_reg    <= 2'h0;
            sync_b_reg    <= 2'h0;
            sync_c_reg    <= 2'h0;
            pin_f_reg     <= 2'h0;
            trig_prev_reg <= 1'b0;
        end
        else
        begin
            sync_a_reg    <= {external_trigger_input, comparator_in};
            sync_b_reg    <= sync_a_reg;
            sync_c_reg    <= sync_b_reg;
            for (int i = 0; i < 2; i++)
                if (sync_b_reg[i] == sync_c_reg[i])
                    pin_f_reg[i] <= sync_b_reg[i];
            trig_prev_reg <= pin_f_reg[1];
        end
    end

    assign trig_f    = pin_f_reg[1];
    assign trig_edge =
        (edge_reg == sac_pkg::EDGE_RISE && trig_f && !trig_prev_reg) ||
        (edge_reg == sac_pkg::EDGE_FALL && !trig_f && trig_prev_reg) ||
        (edge_reg == sac_pkg::EDGE_BOTH && trig_f != trig_prev_reg);

    ////////////////////////////////////////////////////////////////////////
    // Start control

    assign cs_bit  = mode_reg[sac_pkg::MODE_CS_BIT];
    assign trg_bit = mode_reg[sac_pkg::MODE_TRG_BIT];
    assign base    = step_base({mode_reg[sac_pkg::MODE_FR1_BIT],
                                mode_reg[sac_pkg::MODE_FR0_BIT],
                                mode_reg[sac_pkg::MODE_HSC_BIT]});
    assign rate_ok = (base != 5'h00);

    always_comb
    begin
        ctl_next = ctl_reg;
        case (ctl_reg)
            sac_pkg::CTL_STOP:   ctl_next = sac_pkg::CTL_STOP;
            sac_pkg::CTL_ARMED:  if (trig_edge && rate_ok)
                                     ctl_next = sac_pkg::CTL_SINGLE;
            sac_pkg::CTL_SINGLE: if (sar.done)
                                     ctl_next = sac_pkg::CTL_ARMED;
            sac_pkg::CTL_REPEAT: ctl_next = sac_pkg::CTL_REPEAT;
            default:             ctl_next = sac_pkg::CTL_STOP;
        endcase
        if (mode_wr)
        begin
            if (!w_data_reg[sac_pkg::MODE_CS_BIT])
                ctl_next = sac_pkg::CTL_STOP;
            else if (w_data_reg[sac_pkg::MODE_TRG_BIT])
                ctl_next = sac_pkg::CTL_ARMED;
            else
                ctl_next = sac_pkg::CTL_REPEAT;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctl_reg <= sac_pkg::CTL_STOP;
        else
            ctl_reg <= ctl_next;
    end

    assign sar.abort      = mode_wr;
    assign sar.start      = !mode_wr && rate_ok && !sar.busy &&
                            ((ctl_reg == sac_pkg::CTL_REPEAT) ||
                             (ctl_reg == sac_pkg::CTL_ARMED && trig_edge));
    assign sar.step_ticks = osc_reg ? base : 5'(base << 1);
    assign sar.comp       = pin_f_reg[0];

    sac_sar_core u_core (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sar     (sar)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign trial_code            = sar.trial;
    assign sample_enable         = sar.sample;
    assign channel_select        = mode_reg[sac_pkg::MODE_CH_LSB +: sac_pkg::CH_W];
    assign analog_inputs         = pin_mask(insel_reg);
    assign end_of_conversion_irq = irq_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stop_no_start: assert property (
        (!cs_bit) |-> !sar.start)
        else $error("conversion started with operation bit clear");
    a_single_then_wait: assert property (
        (ctl_reg == sac_pkg::CTL_SINGLE && sar.done && !mode_wr)
        |=> (ctl_reg == sac_pkg::CTL_ARMED && !sar.busy))
        else $error("hardware start did not stop after one conversion");
    a_repeat_restart: assert property (
        (ctl_reg == sac_pkg::CTL_REPEAT && sar.done && !mode_wr && rate_ok)
        |-> sar.start)
        else $error("software mode did not restart conversion");
    a_flag_and_irq: assert property (
        sar.done |=> (eoc_flag_reg && end_of_conversion_irq)
        ##1 !end_of_conversion_irq)
        else $error("end of conversion not flagged as a pulse");
    a_mode_write_abort: assert property (
        mode_wr |=> !sar.busy)
        else $error("mode write did not abort conversion");
    a_armed_waits_edge: assert property (
        (ctl_reg == sac_pkg::CTL_ARMED && !trig_edge) |-> !sar.start)
        else $error("armed converter started without trigger edge");
    a_step_rate_mcs: assert property (
        (rate_ok && !osc_reg) |-> (sar.step_ticks == 5'(base << 1)))
        else $error("half clock step length wrong");

endmodule : sac_top

// *** tb/sac_afe_model.sv ***
module sac_afe_model (
    // Clock
    input  wire logic       aclk,
    // Converter side
    input  wire logic [7:0] trial_code,
    input  wire logic [2:0] channel_select,
    input  wire logic       sample_enable,
    output logic            comparator_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held;
    initial held = 8'h00;
    initial comparator_in = 1'b0;
    // Held level must not follow the pin once sampling ends
    always @(posedge aclk)
    begin
        if (sample_enable) held <= 8'(channel_select * 8'h23 + 8'h11);
        comparator_in <= (held >= trial_code);
    end
endmodule : sac_afe_model

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, comparator_in, sample_enable, external_trigger_input;
    logic        end_of_conversion_irq;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0]  trial_code, analog_inputs;
    logic [2:0]  channel_select;
    int          num_errors, comparisons, cycles, t;
    localparam logic [2:0] RATE[4] = '{3'b001, 3'b011, 3'b100, 3'b101};
    localparam int         LEN[4]  = '{80, 40, 50, 100};
    sac_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .comparator_in, .trial_code, .channel_select,
        .sample_enable, .analog_inputs, .external_trigger_input, .end_of_conversion_irq);
    sac_afe_model afe (.aclk, .trial_code, .channel_select, .sample_enable, .comparator_in);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] level(input logic [2:0] ch);
        return 8'(ch * 8'h23 + 8'h11);
    endfunction : level
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        if (seen !== exp) num_errors++;
    endtask : check
    task automatic conclude();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // Counts cycles to the next pulse; limit returned means none came
    task automatic wait_irq(input int limit);
        t = 0;
        do
        begin
            @(posedge aclk);
            t++;
        end while (end_of_conversion_irq !== 1'b1 && t < limit);
    endtask : wait_irq
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 30000) num_errors++;
        if (cycles == 30000) conclude();
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, external_trigger_input} = '0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(sac_pkg::MODE_OFS);
        check(rdat, 32'h01);
        rd(16'hFF40);
        check(32'(rsp), 32'(sac_pkg::RESP_SLVERR));
        wr(sac_pkg::INSEL_OFS, 32'h3);
        check(32'(analog_inputs), 32'h07);
        wr(sac_pkg::INSEL_OFS, 32'h8);
        check(32'(analog_inputs), 32'hFF);
        check(32'(rsp), 32'(sac_pkg::RESP_OKAY));
        // One idle cycle between conversions; every code here is legal
        for (int i = 0; i < 4; i++)
        begin
            wr(sac_pkg::MODE_OFS, 32'({2'b10, RATE[i][2:1], 3'(2 * i + 1), RATE[i][0]}));
            wait_irq(1000);
            wait_irq(1000);
            check(t - 2 * LEN[i], 32'd1);
            check(32'(channel_select), 2 * i + 1);
            rd(sac_pkg::RESULT_OFS);
            check(rdat, 32'(level(3'(2 * i + 1))));
        end
        wr(sac_pkg::OSC_OFS, 32'h1);
        wr(sac_pkg::MODE_OFS, 32'hA1);
        wait_irq(1000);
        wait_irq(1000);
        check(t, 32'd101);
        rd(sac_pkg::RESULT_OFS);
        check(rdat, 32'(level(3'd0)));
        wr(sac_pkg::OSC_OFS, 32'h0);
        wr(sac_pkg::MODE_OFS, 32'h83);
        repeat (60) @(posedge aclk);
        wr(sac_pkg::MODE_OFS, 32'h8D);
        wait_irq(1000);
        rd(sac_pkg::RESULT_OFS);
        check(rdat, 32'(level(3'd6)));
        wr(sac_pkg::MODE_OFS, 32'h0D);
        wait_irq(500);
        check(t, 500);
        rd(sac_pkg::STATUS_OFS);
        check(rdat, 32'h1);
        wr(sac_pkg::STATUS_OFS, 32'h1);
        rd(sac_pkg::STATUS_OFS);
        check(rdat, 32'h0);
        wr(sac_pkg::EDGE_OFS, 32'h1);
        wr(sac_pkg::MODE_OFS, 32'hE4);
        wait_irq(300);
        check(t, 300);
        external_trigger_input <= 1'b1;
        wait_irq(1000);
        check(32'(t < 1000), 1);
        rd(sac_pkg::RESULT_OFS);
        check(rdat, 32'(level(3'd2)));
        rd(sac_pkg::STATUS_OFS);
        check(rdat, 32'h1);
        wait_irq(1000);
        check(t, 1000);
        conclude();
    end
endmodule : testbench
